// *** wrxs_pkg.sv ***
package wrxs_pkg;
    // adc and calibration scaling
    localparam int          ADC_W          = 12;
    localparam logic [11:0] ADC_FULL_CODE  = 12'hFFF;  // 4095 counts at 2.1 V
    localparam int          ADC_FS_MV      = 2100;
    localparam logic [11:0] CAL_UNITY_CODE = 12'h6DB;  // 1755
    localparam logic [11:0] CAL_GND_CODE   = 12'h000;
    // thresholds in adc counts (mv scaled to full scale), die limits in degrees c
    localparam int          OVP_MV         = 12000;
    localparam int          TS_TRIP_MV     = 600;
    localparam int          DIE_SD_C       = 140;
    localparam int          DIE_WARN_C     = 130;
    localparam int          RECTIFIER_VOLTAGE_DIV      = 8;   // rectifier divider ratio into adc
    localparam logic [11:0] OVP_CODE  = 12'((OVP_MV / RECTIFIER_VOLTAGE_DIV) * 4095 / ADC_FS_MV);
    localparam logic [11:0] TS_CODE   = 12'(TS_TRIP_MV * 4095 / ADC_FS_MV);
    localparam logic [11:0] OVP_HYST_CODE  = 12'h040;
    localparam logic [11:0] UVLO_CODE      = 12'h1A0;
    localparam logic [11:0] TARGET_BASE    = 12'h300;
    localparam int          TARGET_SHIFT   = 3;       // target drops one code per 8 current codes
    // sample period: adc conversion every 15 us (about 66.7 ksa/s)
    localparam int          SAMPLE_NS      = 15000;
    localparam int          CLK_NS         = 10;
    localparam int          SAMPLE_CYC     = SAMPLE_NS / CLK_NS;
    localparam int          SAMPLE_W       = 11;
    // control request codes sent to the packet engine
    typedef enum logic [1:0] {
        WRXS_REQ_HOLD,
        WRXS_REQ_RAISE,
        WRXS_REQ_LOWER
    } wrxs_req_t;
    // one set of adc samples
    typedef struct packed {
        logic [11:0] rect;
        logic [11:0] iout;
        logic [11:0] ts;
        logic [7:0]  die_c;
        logic [11:0] gain_pin;
        logic [11:0] offs_pin;
    } wrxs_adc_t;
    // fault cause bits
    typedef struct packed {
        logic shutdown;
        logic die_hot;
        logic therm;
        logic over_cur;
        logic over_volt;
    } wrxs_cause_t;
    // axi4-lite map
    localparam logic [7:0] REG_STATUS  = 8'h00;  // live cause, clamp, sync, overheat
    localparam logic [7:0] REG_CAUSE   = 8'h04;  // sticky alert causes, write 1 clear
    localparam logic [7:0] REG_POWER   = 8'h08;  // reported received power mw
    localparam logic [7:0] REG_CTRL    = 8'h0C;  // bit0 fod force off
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : wrxs_pkg

// *** wrxs_supervisor.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// [R01] sample rectifier voltage and output current periodically and feed the decision logic
// [R02] below target voltage, request more transmitted power
// [R03] above target voltage, request less transmitted power
// [R04] target voltage falls as load current rises
// [R05] above 12 V keep requesting lower power and turn the clamp on
// [R06] release clamp only below threshold minus hysteresis
// [R07] passive bridge at startup, synchronous once above lockout
// [R08] alert low on shutdown, 140 C, thermistor trip, over-current or over-voltage
// [R09] alert released in normal operation, cause kept in a readable register
// [R10] shutdown input high means shutdown, low means active
// [R11] shut the receiver down above 140 C die temperature
// [R12] above 130 C set overheat flag and send end transfer
// [R13] thermistor below 0.6 V triggers external over-temperature shutdown
// [R14] charge done input high issues end transfer
// [R15] reported power is gain times internal power plus offset
// [R16] pin codes scaled to 4095 at 2.1 V; gain code/1755, offset code-1755
// [R17] 0.9 V on both pins gives gain 1 and offset 0
// [R18] both pins at ground disable foreign object detection
// [R19] after end transfer keep repeating it until voltage drops below lockout
// [R20] alert released only after all faults clear and shutdown is low
module wrxs_supervisor (
    input  wire logic                core_clk,     // 100 MHz clock
    input  wire logic                rstn,         // synchronous reset, active low
    input  wire logic                shutdown_in,  // active-low chip activate pin
    input  wire logic                charge_done,  // end of charge pin, active high
    input  wire logic                over_cur,     // current-limit comparator
    input  wire wrxs_pkg::wrxs_adc_t adc_data,     // converter results
    input  wire logic                adc_valid,    // converter result strobe
    input  wire logic [15:0]         rx_power_mw,  // internal received power
    output logic                     adc_start,    // start a conversion
    output logic                     req_valid,    // control request strobe
    output wrxs_pkg::wrxs_req_t      req_code,     // raise, lower or hold
    output logic                     ept_send,     // end power transfer request
    output logic                     rpp_valid,    // reported power ready
    output logic [15:0]              rpp_mw,       // reported received power
    output logic                     fod_enable,   // foreign object detection on
    output logic                     overvoltage_clamp_pin_oe, // clamp drive
    output logic                     sync_mode,    // rectifier synchronous
    output logic                     rx_shutdown,  // receiver off
    output logic                     alert_n_oe,   // open-drain alert pulls low
    output logic                     die_overheat_flag, // die above warning level
    // axi4-lite slave
    input  wire logic [7:0]          s_awaddr,     // write address
    input  wire logic                s_awvalid,    // write address valid
    output logic                     s_awready,    // write address ready
    input  wire logic [31:0]         s_wdata,      // write data
    input  wire logic [3:0]          s_wstrb,      // byte enables
    input  wire logic                s_wvalid,     // write data valid
    output logic                     s_wready,     // write data ready
    output logic [1:0]               s_bresp,      // write response
    output logic                     s_bvalid,     // write response valid
    input  wire logic                s_bready,     // write response ready
    input  wire logic [7:0]          s_araddr,     // read address
    input  wire logic                s_arvalid,    // read address valid
    output logic                     s_arready,    // read address ready
    output logic [31:0]              s_rdata,      // read data
    output logic [1:0]               s_rresp,      // read response
    output logic                     s_rvalid,     // read response valid
    input  wire logic                s_rready      // read response ready
);
    import wrxs_pkg::*;

    logic [1:0]        shut_sync;
    logic [1:0]        done_sync;
    logic [1:0]        oc_sync;
    logic [SAMPLE_W-1:0] samp_cnt;
    wrxs_adc_t         smp;
    logic              smp_new;
    logic [11:0]       target;
    logic [11:0]       cur_drop;
    wrxs_cause_t       live;
    wrxs_cause_t       cause;
    logic              ept_latched;
    logic              fod_off;
    logic [31:0]       prod;
    logic signed [17:0] offs;
    logic signed [18:0] power_sum;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic [4:0]        next_cause;

    // pin synchronisers, two stages each
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            shut_sync <= 2'h3;
            done_sync <= 2'h0;
            oc_sync   <= 2'h0;
        end else begin
            shut_sync <= {shut_sync[0], shutdown_in};
            done_sync <= {done_sync[0], charge_done};
            oc_sync   <= {oc_sync[0], over_cur};
        end
    end

    // periodic conversion request
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            samp_cnt  <= '0;
            adc_start <= 1'b0;
        end else if (samp_cnt == SAMPLE_W'(SAMPLE_CYC - 1)) begin
            samp_cnt  <= '0;
            adc_start <= 1'b1; // [R01]
        end else begin
            samp_cnt  <= samp_cnt + 1'b1;
            adc_start <= 1'b0;
        end
    end

    // capture results for the decision logic
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            // idle readings: thermistor cold, calibration at unity, so no false trip
            smp     <= '{rect: 12'h000, iout: 12'h000, ts: ADC_FULL_CODE, die_c: 8'h00,
                         gain_pin: CAL_UNITY_CODE, offs_pin: CAL_UNITY_CODE};
            smp_new <= 1'b0;
        end else begin
            smp_new <= adc_valid;
            if (adc_valid) begin
                smp <= adc_data; // [R01]
            end
        end
    end

    // load-dependent voltage target
    assign cur_drop = smp.iout >> TARGET_SHIFT;
    assign target   = (cur_drop > TARGET_BASE) ? 12'h000 : TARGET_BASE - cur_drop; // [R04]

    // live fault conditions
    always_comb begin
        live.shutdown  = shut_sync[1];                      // [R10]
        live.die_hot   = smp.die_c > 8'(DIE_SD_C);          // [R11]
        live.therm     = smp_valid_ts();                    // [R13]
        live.over_cur  = oc_sync[1];
        live.over_volt = overvoltage_clamp_pin_oe;
    end

    function automatic logic smp_valid_ts();
        return smp.ts < TS_CODE;
    endfunction : smp_valid_ts

    // control requests, one per sample
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            req_valid <= 1'b0;
            req_code  <= WRXS_REQ_HOLD;
        end else begin
            req_valid <= smp_new && sync_mode && !rx_shutdown;
            if (smp_new) begin
                if (smp.rect > OVP_CODE || smp.rect > target) begin
                    req_code <= WRXS_REQ_LOWER; // [R03] [R05]
                end else if (smp.rect < target) begin
                    req_code <= WRXS_REQ_RAISE; // [R02]
                end else begin
                    req_code <= WRXS_REQ_HOLD;
                end
            end
        end
    end

    // over-voltage clamp with hysteresis
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            overvoltage_clamp_pin_oe <= 1'b0;
        end else if (smp.rect > OVP_CODE) begin
            overvoltage_clamp_pin_oe <= 1'b1; // [R05]
        end else if (smp.rect < OVP_CODE - OVP_HYST_CODE) begin
            overvoltage_clamp_pin_oe <= 1'b0; // [R06]
        end
    end

    // rectifier mode: passive until above lockout
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sync_mode <= 1'b0;
        end else if (smp.rect > UVLO_CODE) begin
            sync_mode <= 1'b1; // [R07]
        end else if (smp.rect < UVLO_CODE) begin
            sync_mode <= 1'b0; // [R07]
        end
    end

    // shutdown and overheat flag
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rx_shutdown       <= 1'b1;
            die_overheat_flag <= 1'b0;
        end else begin
            rx_shutdown       <= live.shutdown || live.die_hot || live.therm; // [R10] [R11] [R13]
            die_overheat_flag <= smp.die_c > 8'(DIE_WARN_C); // [R12]
        end
    end

    // end power transfer latch, repeated until below lockout
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ept_latched <= 1'b0;
        end else if (done_sync[1] || die_overheat_flag) begin
            ept_latched <= 1'b1; // [R12] [R14]
        end else if (smp.rect < UVLO_CODE) begin
            ept_latched <= 1'b0; // [R19]
        end
    end

    // one end packet request per sample period while latched
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ept_send <= 1'b0;
        end else begin
            ept_send <= ept_latched && adc_start; // [R19]
        end
    end

    // alert: low while any cause stands
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            alert_n_oe <= 1'b0;
        end else begin
            alert_n_oe <= |live; // [R08] [R09] [R20]
        end
    end

    // sticky cause, set wins over write-one-clear
    always_comb begin
        next_cause = cause;
        if (aw_got && w_got && aw_addr == REG_CAUSE && w_strb[0]) begin
            next_cause = cause & ~w_data[4:0];
        end
        next_cause = next_cause | live; // [R09]
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cause <= '0;
        end else begin
            cause <= next_cause;
        end
    end

    // foreign object detection enable
    assign fod_enable = !fod_off &&
        !(smp.gain_pin == CAL_GND_CODE && smp.offs_pin == CAL_GND_CODE); // [R18]

    // reported power = power * gain_code / 1755 + (offset_code - 1755)
    assign prod      = 32'(rx_power_mw) * 32'(smp.gain_pin);                // [R15] [R16]
    assign offs      = 18'(signed'({6'h00, smp.offs_pin})) - 18'(CAL_UNITY_CODE); // [R16] [R17]
    assign power_sum = 19'(signed'({1'b0, 18'(prod / 32'(CAL_UNITY_CODE))})) + 19'(offs);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rpp_mw    <= '0;
            rpp_valid <= 1'b0;
        end else begin
            rpp_valid <= smp_new && fod_enable;
            if (smp_new) begin
                rpp_mw <= power_sum[18] ? 16'h0000 :
                          (power_sum > 19'sh0FFFF ? 16'hFFFF : power_sum[15:0]); // [R15]
            end
        end
    end

    // axi write channel: address and data in either order
    assign s_awready = !aw_got && !s_bvalid;
    assign s_wready  = !w_got && !s_bvalid;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            aw_addr  <= '0;
            w_data   <= '0;
            w_strb   <= '0;
            s_bvalid <= 1'b0;
            s_bresp  <= RESP_OKAY;
            fod_off  <= 1'b0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_got  <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_got  <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            if (aw_got && w_got) begin
                aw_got   <= 1'b0;
                w_got    <= 1'b0;
                s_bvalid <= 1'b1;
                if (aw_addr == REG_CTRL) begin
                    if (w_strb[0]) begin
                        fod_off <= w_data[0];
                    end
                    s_bresp <= RESP_OKAY;
                end else if (aw_addr == REG_CAUSE || aw_addr == REG_STATUS
                             || aw_addr == REG_POWER) begin
                    s_bresp <= RESP_OKAY;
                end else begin
                    s_bresp <= RESP_SLVERR;
                end
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // axi read channel
    assign s_arready = !s_rvalid;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= '0;
            s_rresp  <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp  <= RESP_OKAY;
            if (s_araddr == REG_STATUS) begin
                s_rdata <= {24'h000000, fod_enable, ept_latched, rx_shutdown,
                            die_overheat_flag, sync_mode, 3'h0} | 32'(live);
            end else if (s_araddr == REG_CAUSE) begin
                s_rdata <= 32'(cause); // [R09]
            end else if (s_araddr == REG_POWER) begin
                s_rdata <= {16'h0000, rpp_mw};
            end else if (s_araddr == REG_CTRL) begin
                s_rdata <= {31'h0, fod_off};
            end else begin
                s_rdata <= '0;
                s_rresp <= RESP_SLVERR;
            end
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end
endmodule : wrxs_supervisor
`default_nettype wire

// *** wrxs_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module wrxs_chk (
    input wire logic                core_clk,                 // clock
    input wire logic                rstn,                     // reset, active low
    input wire logic                shutdown_in,              // shutdown pin
    input wire wrxs_pkg::wrxs_adc_t adc_data,                 // samples
    input wire logic                adc_valid,                // sample strobe
    input wire logic                adc_start,                // conversion start
    input wire logic                req_valid,                // request strobe
    input wire wrxs_pkg::wrxs_req_t req_code,                 // request code
    input wire logic                ept_send,                 // end transfer
    input wire logic                rpp_valid,                // power ready
    input wire logic                overvoltage_clamp_pin_oe, // clamp
    input wire logic                sync_mode,                // synchronous
    input wire logic                rx_shutdown,              // receiver off
    input wire logic                alert_n_oe,               // alert pulled low
    input wire logic                die_overheat_flag         // overheat
);
    import wrxs_pkg::*;
    logic [11:0] last_rect;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // last captured rectifier code
    always_ff @(posedge core_clk) begin
        if (adc_valid) begin
            last_rect <= adc_data.rect;
        end
    end
    property p_req_src; req_valid |-> $past(adc_valid, 2); endproperty
    a_req_src: assert property (p_req_src) else $error("request without sample");
    property p_ovp_set; adc_valid && adc_data.rect > OVP_CODE |-> ##[1:3] overvoltage_clamp_pin_oe;
    endproperty
    a_ovp_set: assert property (p_ovp_set) else $error("clamp not on");
    property p_ovp_low; req_valid && last_rect > OVP_CODE |-> req_code == WRXS_REQ_LOWER;
    endproperty
    a_ovp_low: assert property (p_ovp_low) else $error("no lower request");
    property p_clamp_rel; $fell(overvoltage_clamp_pin_oe) |-> last_rect < OVP_CODE - OVP_HYST_CODE;
    endproperty
    a_clamp_rel: assert property (p_clamp_rel) else $error("clamp released early");
    property p_sync; $rose(sync_mode) |-> last_rect > UVLO_CODE; endproperty
    a_sync: assert property (p_sync) else $error("sync below lockout");
    property p_sd_alert; shutdown_in [*4] |-> alert_n_oe; endproperty
    a_sd_alert: assert property (p_sd_alert) else $error("no alert in shutdown");
    property p_die_sd; adc_valid && adc_data.die_c > DIE_SD_C |-> ##[1:3] rx_shutdown && alert_n_oe;
    endproperty
    a_die_sd: assert property (p_die_sd) else $error("no thermal shutdown");
    property p_die_warn; adc_valid && adc_data.die_c > DIE_WARN_C |-> ##[1:3] die_overheat_flag;
    endproperty
    a_die_warn: assert property (p_die_warn) else $error("no overheat flag");
    property p_ts; adc_valid && adc_data.ts < TS_CODE |-> ##[1:3] alert_n_oe; endproperty
    a_ts: assert property (p_ts) else $error("no thermistor alert");
    property p_ept; ept_send |-> $past(adc_start); endproperty
    a_ept: assert property (p_ept) else $error("end transfer off slot");
    property p_rpp_src; rpp_valid |-> $past(adc_valid, 2); endproperty
    a_rpp_src: assert property (p_rpp_src) else $error("power report without sample");
    c_clamp: cover property ($rose(overvoltage_clamp_pin_oe));
    c_ept: cover property (ept_send);
    c_rpp: cover property (rpp_valid);
endmodule : wrxs_chk
`default_nettype wire

// *** wrxs_tx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module wrxs_tx_model (
    input  wire logic                core_clk,  // clock
    input  wire logic                rstn,      // reset, active low
    input  wire logic                adc_start, // conversion request
    input  wire logic                req_valid, // control request strobe
    input  wire wrxs_pkg::wrxs_req_t req_code,  // control request
    input  wire logic                ept_send,  // end transfer
    input  wire logic                rect_ld,   // load rectifier level
    input  wire wrxs_pkg::wrxs_adc_t env,       // sensed conditions
    output wrxs_pkg::wrxs_adc_t      adc_data,  // converter result
    output logic                     adc_valid  // result strobe
);
    import wrxs_pkg::*;
    logic [11:0] rect;
    logic [1:0]  ept_cnt;
    // power follows requests; the third end transfer removes power
    always_ff @(posedge core_clk) begin
        if (!rstn || rect_ld) begin
            rect    <= env.rect;
            ept_cnt <= 2'h0;
        end else if (ept_send) begin
            ept_cnt <= ept_cnt + 2'h1;
            if (ept_cnt == 2'h2) begin
                rect <= 12'h000;
            end
        end else if (req_valid && req_code == WRXS_REQ_RAISE) begin
            rect <= rect + 12'h001;
        end else if (req_valid && req_code == WRXS_REQ_LOWER) begin
            rect <= rect - 12'h001;
        end
    end
    // conversion answers one cycle after start
    always_ff @(posedge core_clk) begin
        adc_valid     <= rstn && adc_start;
        adc_data      <= {rect, env.iout, env.ts, env.die_c, env.gain_pin, env.offs_pin};
    end
endmodule : wrxs_tx_model
`default_nettype wire

// *** wrxs_supervisor_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module wrxs_supervisor_tb_top;
    import wrxs_pkg::*;
    logic        core_clk, rstn, shutdown_in, charge_done, over_cur, rect_ld;
    logic        s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [3:0]  s_wstrb;
    logic [15:0] rx_power_mw, rpp_mw;
    wrxs_adc_t   env, adc_data;
    logic        adc_valid, adc_start, req_valid, ept_send, rpp_valid, fod_enable;
    logic        overvoltage_clamp_pin_oe, sync_mode, rx_shutdown, alert_n_oe;
    logic        die_overheat_flag, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]  s_bresp, s_rresp, rr;
    wrxs_req_t   req_code, rc;
    int          err_total = 0, cmp_count = 0, cyc = 0, ept_n = 0;
    wrxs_supervisor i_wrxs_supervisor (.*);
    wrxs_tx_model   i_wrxs_tx_model (.*);
    always #5 core_clk = ~core_clk;
    // cycle ceiling and end transfer count
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (ept_send) ept_n <= ept_n + 1;
        if (cyc == 80000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic smp(input int n);
        repeat (n * 1500 + 10) @(posedge core_clk);
    endtask : smp
    task automatic load(input logic [11:0] r);
        env.rect <= r;
        rect_ld  <= 1'b1;
        @(posedge core_clk);
        rect_ld  <= 1'b0;
    endtask : load
    task automatic wreq(output wrxs_req_t c);
        int i;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (!req_valid && i < 3100);
        c = req_code;
    endtask : wreq
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        rr = s_bresp;
        s_bready <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        rd = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
        @(posedge core_clk);
    endtask : rdr
    task automatic sc_loop;
        chk(sync_mode, 1'b0);
        load(12'h2F0);
        wreq(rc);
        wreq(rc);
        chk(rc, WRXS_REQ_RAISE);
        chk(sync_mode, 1'b1);
        env.iout <= 12'h100;
        wreq(rc);
        wreq(rc);
        chk(rc, WRXS_REQ_LOWER);
        env.iout <= 12'h000;
    endtask : sc_loop
    task automatic sc_fod;
        rdr(REG_CTRL);
        chk(rd, 32'h0);
        rx_power_mw <= 16'h03E8;
        smp(1);
        chk(rpp_mw, 16'h03E8);
        chk(fod_enable, 1'b1);
        env.gain_pin <= CAL_UNITY_CODE * 2;
        env.offs_pin <= CAL_UNITY_CODE + 12'h064;
        smp(1);
        chk(rpp_mw, 16'h0834);
        wr(REG_CTRL, 32'h1);
        chk(rr, RESP_OKAY);
        chk(fod_enable, 1'b0);
        rdr(REG_POWER);
        chk(rd, 32'h834);
        wr(REG_CTRL, 32'h0);
        rdr(8'h10);
        chk(rr, RESP_SLVERR);
        wr(8'h10, 32'h0);
        chk(rr, RESP_SLVERR);
        env.gain_pin <= CAL_GND_CODE;
        env.offs_pin <= CAL_GND_CODE;
        smp(1);
        chk(fod_enable, 1'b0);
    endtask : sc_fod
    task automatic sc_ovp;
        load(12'hC00);
        smp(2);
        chk(overvoltage_clamp_pin_oe, 1'b1);
        chk(alert_n_oe, 1'b1);
        wreq(rc);
        chk(rc, WRXS_REQ_LOWER);
        load(OVP_CODE - 12'h020);
        smp(2);
        chk(overvoltage_clamp_pin_oe, 1'b1);
        load(12'h300);
        smp(2);
        chk(overvoltage_clamp_pin_oe, 1'b0);
        chk(alert_n_oe, 1'b0);
        rdr(REG_CAUSE);
        chk(rd[0], 1'b1);
        wr(REG_CAUSE, 32'h1F);
        rdr(REG_CAUSE);
        chk(rd, 32'h0);
    endtask : sc_ovp
    task automatic sc_pins;
        int b;
        b = ept_n;
        env.ts <= 12'h100;
        smp(1);
        chk(alert_n_oe, 1'b1);
        env.ts <= 12'hFFF;
        over_cur <= 1'b1;
        smp(1);
        chk(alert_n_oe, 1'b1);
        over_cur <= 1'b0;
        smp(1);
        chk(alert_n_oe, 1'b0);
        shutdown_in <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk(alert_n_oe & rx_shutdown, 1'b1);
        shutdown_in <= 1'b0;
        charge_done <= 1'b1;
        smp(3);
        chk(ept_n > b, 1'b1);
        charge_done <= 1'b0;
        smp(4);
    endtask : sc_pins
    task automatic sc_temp;
        int b;
        load(12'h2F0);
        b = ept_n;
        env.die_c <= 8'h87;
        smp(1);
        chk(die_overheat_flag, 1'b1);
        env.die_c <= 8'h19;
        smp(7);
        chk(ept_n - b >= 2, 1'b1);
        b = ept_n;
        smp(2);
        chk(ept_n - b, 0);
        env.die_c <= 8'h91;
        smp(1);
        chk(rx_shutdown & alert_n_oe, 1'b1);
    endtask : sc_temp
    // reset, then one scenario after another
    initial begin
        core_clk    = 1'b0;
        rstn        = 1'b0;
        shutdown_in = 1'b0;
        charge_done = 1'b0;
        over_cur    = 1'b0;
        rect_ld     = 1'b0;
        s_awvalid   = 1'b0;
        s_wvalid    = 1'b0;
        s_bready    = 1'b0;
        s_arvalid   = 1'b0;
        s_rready    = 1'b0;
        s_awaddr    = 8'h00;
        s_araddr    = 8'h00;
        s_wdata     = 32'h0;
        s_wstrb     = 4'hF;
        rx_power_mw = 16'h0000;
        env = '{12'h000, 12'h000, 12'hFFF, 8'h19, CAL_UNITY_CODE, CAL_UNITY_CODE};
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        sc_loop();
        sc_fod();
        sc_ovp();
        sc_pins();
        sc_temp();
        print_verdict();
    end
endmodule : wrxs_supervisor_tb_top
bind wrxs_supervisor wrxs_chk i_wrxs_chk (.*);
`default_nettype wire
